// [rtl/adcc_conversion_control.sv]
// conversion control for a ten-bit successive-approximation converter
// assumes: the core returns one result bit per conversion period, msb
// first, on core_bit; core_bit comes from the analogue side (async)
// How it works
// - five inputs on the small package, eight on the larger ones
// - every completed conversion yields a ten-bit result
// - software picks each reference from supply rails or reference pins
// - conversions may run in sleep only on the internal rc clock
// - four registers: result high, result low, primary, secondary control
// - primary: clock select 7:6, channel 5:3, go 2, bit 1 unused, power 0
// - high select plus low bits pick osc divide or the internal rc clock
// - channel select code n routes analogue input n to the converter
// - writing go starts conversion; go reads 1 until hardware clears it; here a write of power 0 also clears it
// - power bit 1 powers the converter, 0 shuts it off
// - primary bit 1 is unimplemented and always reads zero
// - secondary control sets pins analogue or digital, up to two as references
// - on completion load result, clear go, set done flag
// - justify 1 right-aligns result, 0 left-aligns it
// - each conversion takes at least twelve conversion periods
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
`include "adcc_regs.svh"

module adcc_conversion_control
    import adcc_pkg::*;
#(
    parameter int NUM_CHANNELS = 8,   // 5 on the small package
    parameter int RESULT_BITS  = 10
) (
    input  wire logic                  ref_clk,  // 20 mhz system clock
    input  wire logic                  rst,      // async, active high
    input  wire adcc_pkg::adcc_bus_req_t bus_req, // register port request
    output logic [7:0]                 rd_data,  // read data, next cycle
    input  wire logic                  sleep,    // device is in sleep
    input  wire logic                  core_bit, // comparator decision
    output adcc_pkg::adcc_core_ctl_t   core_ctl, // controls to the core
    output logic                       irq       // level interrupt
);
    import adcc_pkg::*;

    localparam int DIVW = 7;

    // which analogue pins are inputs for a port configuration code
    function automatic logic [9:0] port_map(input logic [3:0] cfg);
        // bits 9:8 = high ref on pin, low ref on pin; 7:0 analogue pins
        unique case (cfg)
            4'h0: port_map = {2'b00, 8'hff};
            4'h1: port_map = {2'b10, 8'hf7};
            4'h2: port_map = {2'b00, 8'h1f};
            4'h3: port_map = {2'b10, 8'h17};
            4'h4: port_map = {2'b00, 8'h0b};
            4'h5: port_map = {2'b10, 8'h03};
            4'h6, 4'h7: port_map = {2'b00, 8'h00};
            4'h8: port_map = {2'b11, 8'hf3};
            4'h9: port_map = {2'b00, 8'h3f};
            4'ha: port_map = {2'b10, 8'h37};
            4'hb: port_map = {2'b11, 8'h33};
            4'hc: port_map = {2'b11, 8'h13};
            4'hd: port_map = {2'b11, 8'h03};
            4'he: port_map = {2'b00, 8'h01};
            4'hf: port_map = {2'b11, 8'h01};
        endcase
    endfunction

    // divide ratio for the conversion clock
    function automatic logic [DIVW-1:0] div_of(input logic [2:0] sel);
        unique case (sel)
            3'b000: div_of = 7'h02;
            3'b001: div_of = 7'h08;
            3'b010: div_of = 7'h20;
            3'b100: div_of = 7'h04;
            3'b101: div_of = 7'h10;
            3'b110: div_of = 7'h40;
            default: div_of = 7'(`ADCC_RC_DIV);
        endcase
    endfunction

    logic [7:0]             prim_ff, nxt_prim;
    logic [7:0]             sec_ff, nxt_sec;
    logic [RESULT_BITS-1:0] result_ff, nxt_result;
    logic [RESULT_BITS-1:0] shift_ff, nxt_shift;
    logic [0:0]             stat_ff, nxt_stat;
    logic [0:0]             mask_ff, nxt_mask;
    logic [7:0]             rd_ff, nxt_rd;
    logic [DIVW-1:0]        div_ff, nxt_div;
    logic [3:0]             per_ff, nxt_per;
    adcc_state_t            st_ff, nxt_st;
    logic                   bit_s1_ff, bit_s2_ff;

    logic [2:0]  clk_sel;
    logic        use_rc;
    logic        tick;
    logic        go_wr;
    logic        pwr_off_wr;
    logic        done_evt;
    logic [9:0]  pmap;
    logic [7:0]  res_hi, res_lo;

    assign clk_sel = {sec_ff[`ADCC_S_CLKSEL_HIGH],
                      prim_ff[`ADCC_P_CLKSEL_HI:`ADCC_P_CLKSEL_LO]};
    assign use_rc  = (clk_sel[1:0] == 2'b11);
    assign pmap    = port_map(sec_ff[`ADCC_S_PORTCFG_HI:`ADCC_S_PORTCFG_LO]);
    // go and power must both be set in the same write to start
    assign go_wr   = bus_req.wr
                   && bus_req.addr == `ADCC_OFS_CTRL_PRIMARY
                   && bus_req.wdata[`ADCC_P_GO]
                   && bus_req.wdata[`ADCC_P_POWER];
    // a power-off write stops the sequencer on the edge that clears go
    assign pwr_off_wr = bus_req.wr
                   && bus_req.addr == `ADCC_OFS_CTRL_PRIMARY
                   && !bus_req.wdata[`ADCC_P_POWER];
    assign tick    = (div_ff == div_of(clk_sel) - 7'h01);

    // justified views of the result pair
    always_comb begin
        if (sec_ff[`ADCC_S_JUSTIFY]) begin
            res_hi = {6'h00, result_ff[9:8]};
            res_lo = result_ff[7:0];
        end else begin
            res_hi = result_ff[9:2];
            res_lo = {result_ff[1:0], 6'h00};
        end
    end

    // sequencer: one conversion period per result bit plus two
    always_comb begin
        nxt_st     = st_ff;
        nxt_div    = tick ? 7'h00 : div_ff + 7'h01;
        nxt_per    = per_ff;
        nxt_shift  = shift_ff;
        nxt_result = result_ff;
        done_evt   = 1'b0;
        unique case (st_ff)
            ADCC_IDLE: begin
                nxt_div = 7'h00;
                nxt_per = 4'h0;
                // sleep halts the oscillator divide, only rc keeps going
                if (go_wr && prim_ff[`ADCC_P_POWER]
                    && !(sleep && !use_rc)) begin
                    nxt_st = ADCC_CONV;
                end
            end
            ADCC_CONV: begin
                if (!prim_ff[`ADCC_P_POWER] || pwr_off_wr) begin
                    nxt_st = ADCC_IDLE;
                end else if (tick && !(sleep && !use_rc)) begin
                    nxt_per = per_ff + 4'h1;
                    if (per_ff >= 4'h1 && per_ff <= 4'(RESULT_BITS)) begin
                        nxt_shift = {shift_ff[RESULT_BITS-2:0], bit_s2_ff};
                    end
                    if (per_ff == 4'(`ADCC_CONV_PERIODS - 1)) begin
                        nxt_st = ADCC_DONE;
                    end
                end
            end
            ADCC_DONE: begin
                nxt_result = shift_ff;
                done_evt   = 1'b1;
                nxt_st     = ADCC_IDLE;
            end
            default: nxt_st = ADCC_IDLE;
        endcase
    end

    // register writes and status
    always_comb begin
        nxt_prim = prim_ff;
        nxt_sec  = sec_ff;
        nxt_mask = mask_ff;
        nxt_stat = stat_ff;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                `ADCC_OFS_CTRL_PRIMARY: begin
                    nxt_prim = bus_req.wdata & 8'hfd;
                    // go only sets while powered; software clears it only by writing power 0
                    nxt_prim[`ADCC_P_GO] = (bus_req.wdata[`ADCC_P_GO]
                        && bus_req.wdata[`ADCC_P_POWER]
                        && prim_ff[`ADCC_P_POWER]
                        && !(sleep && !use_rc))
                        || prim_ff[`ADCC_P_GO];
                end
                `ADCC_OFS_CTRL_SECOND:
                    nxt_sec = bus_req.wdata & `ADCC_S_WRITE_MASK;
                `ADCC_OFS_IRQ_STATUS:
                    nxt_stat = stat_ff & ~bus_req.wdata[0:0];
                `ADCC_OFS_IRQ_MASK:
                    nxt_mask = bus_req.wdata[0:0];
                default: ;
            endcase
        end
        if (st_ff != ADCC_IDLE && nxt_st == ADCC_IDLE) begin
            nxt_prim[`ADCC_P_GO] = 1'b0;
        end
        if (!nxt_prim[`ADCC_P_POWER]) begin
            nxt_prim[`ADCC_P_GO] = 1'b0;
        end
        // hardware set wins over a software clear in the same cycle
        if (done_evt) begin
            nxt_stat[`ADCC_IRQ_DONE] = 1'b1;
        end
    end

    // read mux, data stands the cycle after the strobe
    always_comb begin
        nxt_rd = 8'h00;
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                `ADCC_OFS_CTRL_PRIMARY: nxt_rd = prim_ff;
                `ADCC_OFS_CTRL_SECOND:  nxt_rd = sec_ff;
                `ADCC_OFS_RES_HIGH:     nxt_rd = res_hi;
                `ADCC_OFS_RES_LOW:      nxt_rd = res_lo;
                `ADCC_OFS_IRQ_STATUS:   nxt_rd = {7'h00, stat_ff};
                `ADCC_OFS_IRQ_MASK:     nxt_rd = {7'h00, mask_ff};
                default:                nxt_rd = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prim_ff   <= `ADCC_RESET_BYTE;
            sec_ff    <= `ADCC_RESET_BYTE;
            result_ff <= '0;
            shift_ff  <= '0;
            stat_ff   <= 1'b0;
            mask_ff   <= 1'b0;
            rd_ff     <= 8'h00;
            div_ff    <= 7'h00;
            per_ff    <= 4'h0;
            st_ff     <= ADCC_IDLE;
            bit_s1_ff <= 1'b0;
            bit_s2_ff <= 1'b0;
        end else begin
            prim_ff   <= nxt_prim;
            sec_ff    <= nxt_sec;
            result_ff <= nxt_result;
            shift_ff  <= nxt_shift;
            stat_ff   <= nxt_stat;
            mask_ff   <= nxt_mask;
            rd_ff     <= nxt_rd;
            div_ff    <= nxt_div;
            per_ff    <= nxt_per;
            st_ff     <= nxt_st;
            bit_s1_ff <= core_bit;
            bit_s2_ff <= bit_s1_ff;
        end
    end

    assign rd_data = rd_ff;
    assign irq     = |(stat_ff & mask_ff);

    // channels beyond the package's count fold to channel 0
    always_comb begin
        core_ctl.channel = (int'(prim_ff[`ADCC_P_CHAN_HI:`ADCC_P_CHAN_LO])
                            < NUM_CHANNELS)
                         ? prim_ff[`ADCC_P_CHAN_HI:`ADCC_P_CHAN_LO]
                         : 3'b000;
        core_ctl.power       = prim_ff[`ADCC_P_POWER];
        // stays high until the result lands, in step with go
        core_ctl.sample      = (st_ff != ADCC_IDLE);
        core_ctl.use_rc      = use_rc;
        core_ctl.analog_pins = pmap[7:0];
        core_ctl.vref_hi_pin = pmap[9];
        core_ctl.vref_lo_pin = pmap[8];
    end

endmodule

// [rtl/adcc_pkg.sv]
// types shared by the converter control block
// assumes: adcc_regs.svh sits on the include path
package adcc_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } adcc_bus_req_t;

    typedef struct packed {
        logic [2:0] channel;
        logic       power;
        logic       sample;
        logic       use_rc;
        logic [7:0] analog_pins;
        logic       vref_hi_pin;
        logic       vref_lo_pin;
    } adcc_core_ctl_t;

    typedef enum logic [2:0] {
        ADCC_IDLE = 3'b001,
        ADCC_CONV = 3'b010,
        ADCC_DONE = 3'b100
    } adcc_state_t;

endpackage

// [rtl/adcc_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes: included by the control module, the assertions and the bench by bare name
`ifndef ADCC_REGS_SVH
`define ADCC_REGS_SVH

`define ADCC_OFS_RES_HIGH      8'h1e
`define ADCC_OFS_CTRL_PRIMARY  8'h1f
`define ADCC_OFS_RES_LOW       8'h9e
`define ADCC_OFS_CTRL_SECOND   8'h9f
`define ADCC_OFS_IRQ_STATUS    8'h0c
`define ADCC_OFS_IRQ_MASK      8'h8c

`define ADCC_P_CLKSEL_HI       7
`define ADCC_P_CLKSEL_LO       6
`define ADCC_P_CHAN_HI         5
`define ADCC_P_CHAN_LO         3
`define ADCC_P_GO              2
`define ADCC_P_POWER           0

`define ADCC_S_JUSTIFY         7
`define ADCC_S_CLKSEL_HIGH     6
`define ADCC_S_PORTCFG_HI      3
`define ADCC_S_PORTCFG_LO      0
`define ADCC_S_WRITE_MASK      8'hcf

`define ADCC_IRQ_DONE          0

`define ADCC_RESET_BYTE        8'h00

`define ADCC_CONV_PERIODS      12
`define ADCC_RC_DIV            64

`endif

// [sim/adcc_conversion_control_sva.sv]
// port assertions for the converter control block
// assumes: bound to adcc_conversion_control, one clock domain
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_conversion_control_sva
    import adcc_pkg::*;
#(
    parameter int NUM_CHANNELS = 8,
    parameter int RESULT_BITS  = 10
) (
    input wire logic                     ref_clk,  // clock
    input wire logic                     rst,      // reset
    input wire adcc_pkg::adcc_bus_req_t  bus_req,  // register request
    input wire logic [7:0]               rd_data,  // read data
    input wire logic                     sleep,    // device sleeps
    input wire logic                     core_bit, // core decision
    input wire adcc_pkg::adcc_core_ctl_t core_ctl, // core controls
    input wire logic                     irq       // interrupt
);
    logic [10:0] run_ff;
    logic        wr_pri;
    logic        rd_pri;
    assign wr_pri = bus_req.wr && bus_req.addr == `ADCC_OFS_CTRL_PRIMARY;
    assign rd_pri = bus_req.rd && bus_req.addr == `ADCC_OFS_CTRL_PRIMARY;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            run_ff <= 11'h000;
        else
            run_ff <= core_ctl.sample ? run_ff + 11'h001 : 11'h000;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    AST_RD_IDLE: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
        else $error("read data not zero outside a read");
    AST_BIT1_ZERO: assert property ($past(rd_pri) |-> !rd_data[1])
        else $error("unused control bit reads one");
    AST_GO_READ: assert property ($past(rd_pri) |->
        rd_data[`ADCC_P_GO] == $past(core_ctl.sample))
        else $error("go flag disagrees with conversion");
    AST_NO_GO_OFF: assert property (wr_pri && !core_ctl.power |=>
        !core_ctl.sample) else $error("conversion started unpowered");
    AST_GO_START: assert property (wr_pri && bus_req.wdata[2] &&
        bus_req.wdata[0] && core_ctl.power && !core_ctl.sample && !sleep
        |=> core_ctl.sample) else $error("go write did not start");
    AST_OFF_STOP: assert property (!core_ctl.power |=>
        !core_ctl.sample) else $error("converter runs while off");
    AST_MIN_TIME: assert property ($fell(core_ctl.sample) &&
        core_ctl.power |-> run_ff >= 11'h018)
        else $error("conversion shorter than twelve periods");
    AST_CHAN: assert property (wr_pri && !core_ctl.sample |=>
        core_ctl.channel == $past(bus_req.wdata[5:3]))
        else $error("channel not routed");
    AST_RC: assert property (wr_pri && !core_ctl.sample |=>
        core_ctl.use_rc == &$past(bus_req.wdata[7:6]))
        else $error("rc clock choice wrong");
    AST_IRQ_CAUSE: assert property ($rose(irq) |->
        $past(core_ctl.sample) || $past(bus_req.wr))
        else $error("interrupt without a cause");
endmodule
bind adcc_conversion_control adcc_conversion_control_sva #(
    .NUM_CHANNELS(NUM_CHANNELS),
    .RESULT_BITS (RESULT_BITS)
) i_adcc_conversion_control_sva (
    .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .sleep(sleep), .core_bit(core_bit), .core_ctl(core_ctl), .irq(irq)
);

// [sim/adcc_conversion_control_tb.sv]
// self-checking bench for the converter control block
// assumes: core model on the far side, one 20 mhz clock
`timescale 1ns/1ps
`include "adcc_regs.svh"
module adcc_conversion_control_tb;
    import adcc_pkg::*;
    localparam logic [7:0] PRI = `ADCC_OFS_CTRL_PRIMARY;
    localparam logic [7:0] SEC = `ADCC_OFS_CTRL_SECOND;
    localparam logic [7:0] STS = `ADCC_OFS_IRQ_STATUS;
    localparam logic [7:0] MSK = `ADCC_OFS_IRQ_MASK;
    logic           ref_clk;
    logic           rst;
    adcc_bus_req_t  bus_req;
    logic [7:0]     rd_data;
    logic           sleep;
    logic           core_bit;
    adcc_core_ctl_t core_ctl;
    logic           irq;
    int             n_fail = 0;
    int             n_compared = 0;
    int             cycles = 0;
    logic [7:0]     d;
    int             divs [8] = '{2, 8, 32, 64, 4, 16, 64, 64};
    logic [7:0]     ofs [5] = '{8'h1f, 8'h9f, 8'h1e, 8'h9e, 8'h55};

    adcc_conversion_control i_adcc_conversion_control (
        .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .sleep(sleep), .core_bit(core_bit), .core_ctl(core_ctl), .irq(irq));
    adcc_core_model i_adcc_core_model (
        .ref_clk(ref_clk), .core_ctl(core_ctl), .core_bit(core_bit));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus_req <= '{a, v, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        @(negedge ref_clk);
        d = rd_data;
    endtask
    task automatic finish_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic t_reset;
        foreach (ofs[i]) begin
            rd(ofs[i]);
            chk(d, 8'h00);
        end
        chk(core_ctl.analog_pins, 8'hff);
        wr(SEC, 8'hf8);
        rd(SEC);
        chk(d, 8'hc8);
        chk(core_ctl.analog_pins, 8'hf3);
        chk({core_ctl.vref_hi_pin, core_ctl.vref_lo_pin, 6'h00},
            8'hc0);
        wr(SEC, 8'h00);
    endtask
    task automatic t_unpowered;
        wr(PRI, 8'h04);
        rd(PRI);
        chk(d, 8'h00);
        wr(PRI, 8'hfb);
        rd(PRI);
        chk(d, 8'hf9);
        chk({core_ctl.use_rc, core_ctl.power, 3'h0, core_ctl.channel},
            8'hc7);
        wr(PRI, 8'h00);
    endtask
    // every clock code, channel code and both result alignments
    task automatic t_conv(input logic [2:0] k);
        logic [9:0] r;
        int         n;
        n = 0;
        r = {10{k[0]}};
        wr(STS, 8'h01);
        wr(SEC, {k[1], k[2], 6'h00});
        sleep <= &k[1:0];
        wr(PRI, {k[1:0], k, 3'b001});
        wr(PRI, {k[1:0], k, 3'b101});
        @(negedge ref_clk);
        chk({core_ctl.use_rc, 4'h0, core_ctl.channel},
            {&k[1:0], 4'h0, k});
        while (core_ctl.sample === 1'b1 && n < 2000) begin
            n++;
            @(negedge ref_clk);
        end
        chk({7'h0, n >= 12 * divs[k]}, 8'h01);
        chk({7'h0, n <= 13 * divs[k] + 4}, 8'h01);
        @(posedge ref_clk);
        sleep <= 1'b0;
        rd(`ADCC_OFS_RES_HIGH);
        chk(d, k[1] ? {6'h00, r[9:8]} : r[9:2]);
        rd(`ADCC_OFS_RES_LOW);
        chk(d, k[1] ? r[7:0] : {r[1:0], 6'h00});
        rd(PRI);
        chk(d, {k[1:0], k, 3'b001});
        rd(STS);
        chk(d, 8'h01);
    endtask
    task automatic t_irq;
        chk({7'h0, irq}, 8'h00);
        wr(MSK, 8'h01);
        @(negedge ref_clk);
        chk({7'h0, irq}, 8'h01);
        wr(STS, 8'h01);
        @(negedge ref_clk);
        chk({7'h0, irq}, 8'h00);
    endtask
    task automatic t_abort;
        wr(PRI, 8'h81);
        wr(PRI, 8'h85);
        wr(PRI, 8'h00);
        @(negedge ref_clk);
        chk({core_ctl.power, core_ctl.sample}, 8'h00);
        rd(STS);
        chk(d, 8'h00);
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // the whole sequence needs about 3300 cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles > 40000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        rst = 1'b1;
        bus_req = '0;
        sleep = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_unpowered();
        for (int k = 0; k < 8; k++)
            t_conv(3'(k));
        t_irq();
        t_abort();
        finish_test();
    end
endmodule

// [sim/adcc_core_model.sv]
// far-side model: input mux and comparator of the converter core
// assumes: fed from core_ctl, answers on the system clock
`timescale 1ns/1ps
module adcc_core_model
    import adcc_pkg::*;
(
    input  wire logic                     ref_clk,  // system clock
    input  wire adcc_pkg::adcc_core_ctl_t core_ctl, // core controls
    output logic                          core_bit  // comparator decision
);
    logic last = 1'b0;
    // input n holds a level whose bits all equal n[0]
    // an unpowered comparator gives no valid answer, so it wanders
    always @(posedge ref_clk) begin
        if (core_ctl.power)
            last <= core_ctl.channel[0];
        else
            last <= ~last;
    end
    assign core_bit = last;
endmodule
